// >>> core/flash_ctl_consts.svh
// constants for the flash lock and status controller: register offsets,
// field positions, reset values and bus timing counts.
// assumes a 200 MHz system clock and a 16-bit asynchronous flash bus.
`ifndef FLASH_CTL_CONSTS_SVH
`define FLASH_CTL_CONSTS_SVH

// flash bus shape
`define FL_ADDR_W        20
`define FL_DATA_W        16

// wishbone register byte offsets
`define REG_CTRL         8'h00
`define REG_ADDR         8'h04
`define REG_WDATA        8'h08
`define REG_PINCFG       8'h0c
`define REG_STATUS       8'h10
`define REG_LOCKCFG      8'h14

// control register fields
`define CTRL_OP_LSB      0
`define CTRL_GO_BIT      8
// pin config fields
`define PIN_PROTECT_BIT  0
`define PIN_USE_IDLE_BIT 1
// status register fields
`define STAT_BUSY_BIT    16
`define STAT_VALID_BIT   17

// operation codes written to the control register
`define OP_SET_LOCK      4'h1
`define OP_CLEAR_LOCK    4'h2
`define OP_SET_LOCKDOWN  4'h3
`define OP_READ_LOCK     4'h4
`define OP_READ_STATUS   4'h5
`define OP_PROGRAM       4'h6
`define OP_ERASE         4'h7

// engine status: only bits 7..1 carry meaning
`define SR_READY_BIT     7
`define SR_VALID_MASK    16'h00fe

// reset values
`define PINCFG_RESET     2'h0
`define OP_RESET         4'h0

// timing in ns and derived cycle counts at the clock rate
`define CLK_MHZ          200
`define T_WE_PULSE_NS    70
`define T_READ_ACC_NS    70
`define T_RECOVER_NS     30
`define WE_CYC   ((`T_WE_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define ACC_CYC  ((`T_READ_ACC_NS * `CLK_MHZ + 999) / 1000)
`define REC_CYC  ((`T_RECOVER_NS * `CLK_MHZ + 999) / 1000)

`endif

// >>> core/flash_ctl_pkg.sv
// types for the flash lock and status controller.
// assumes flash_ctl_consts.svh is on the include path.
`include "flash_ctl_consts.svh"

package flash_ctl_pkg;

  // sequencer steps
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_W1,
    ST_W2,
    ST_WAIT_IDLE,
    ST_POLL_CMD,
    ST_POLL_RD,
    ST_ID_CMD,
    ST_ID_RD,
    ST_ARRAY
  } step_t;

  // pins driven toward the flash
  typedef struct packed {
    logic                  ce_n;
    logic                  oe_n;
    logic                  we_n;
    logic                  rst_n;
    logic                  protect_accel_pin;
    logic [`FL_ADDR_W-1:0] addr;
    logic [`FL_DATA_W-1:0] dq;
    logic                  dq_oe;
  } flash_pins_t;

  // whole controller state
  typedef struct packed {
    step_t                 st;
    logic                  acc;
    logic                  ph;
    logic [7:0]            cnt;
    logic [3:0]            op;
    logic [1:0]            pincfg;
    logic [`FL_ADDR_W-1:0] addr_reg;
    logic [`FL_DATA_W-1:0] wdata;
    logic [`FL_DATA_W-1:0] rdata;
    logic [`FL_DATA_W-1:0] engine_status;
    logic                  status_valid;
    logic                  lock_bit;
    logic                  lockdown_bit;
    flash_pins_t           pins;
    logic                  wb_ack;
    logic [31:0]           wb_dat;
  } ctl_t;

endpackage

// >>> core/flash_lock_host.sv
// host-side controller for a parallel nor flash: issues lock commands,
// reads lock configuration and polls the engine status register.
// assumes flash pins are sampled synchronously and wishbone runs on clk_i.
`timescale 1ns/1ps
`include "flash_ctl_consts.svh"

// Notes on behaviour
// RL1: device locks block when lock-down set
// RL2: issue set, clear, lock-down per block
// RL3: pin rise keeps lock bits
// RL4: pin rise from 011 depends on history
// RL5: pin fall returns to low states
// RL6: pin fall from 110 locks block
// RL7: status sixteen bits, reserved bits masked
// RL8: status bit seven means engine ready
// RL9: status bit six means erase suspended
// RL10: status bit five means erase failed
// RL11: status bit four means program failed
// RL12: status bit three means bad pin level
// RL13: status bit two means program suspended
// RL14: status bit one means locked block abort
// RL15: ignore bits six to one while busy
// RL16: bits five and four together: bad sequence
// RL17: bit three sampled only by operations
// RL18: lock bit checked only by operations
// RL19: completion by ready bit or idle pin
// RL20: lock bits read after identifier command
// RL21: data bit zero locked, one locked-down
// RL22: reset leaves every block locked
// RL23: lock commands follow fixed state table
// RL24: locked blocks refuse erase and program
// RL25: each block keeps its own state
module flash_lock_host
  import flash_ctl_pkg::*;
#(
  parameter int             ADDR_W        = `FL_ADDR_W,
  parameter int             DATA_W        = `FL_DATA_W,
  parameter int             BLOCK_W       = 15,      // word address bits inside a block
  parameter logic [14:0]    LOCK_OFS      = 15'h0002, // lock config word in id space
  parameter logic [7:0]     CMD_LOCK_SET  = 8'h60,
  parameter logic [7:0]     CMD_SET_LOCK  = 8'h01,
  parameter logic [7:0]     CMD_CLR_LOCK  = 8'hd0,
  parameter logic [7:0]     CMD_LOCKDOWN  = 8'h2f,
  parameter logic [7:0]     CMD_READ_ID   = 8'h90,
  parameter logic [7:0]     CMD_READ_STAT = 8'h70,
  parameter logic [7:0]     CMD_READ_ARR  = 8'hff,
  parameter logic [7:0]     CMD_PROGRAM   = 8'h40,
  parameter logic [7:0]     CMD_ERASE     = 8'h20,
  parameter logic [7:0]     CMD_CONFIRM   = 8'hd0
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // flash side
  input  wire logic [`FL_DATA_W-1:0] dq_i,
  input  wire logic               engine_idle_pin_i,
  output flash_pins_t             flash_o
);

  // the package struct fixes the flash bus shape, so refuse anything else
  if (ADDR_W != `FL_ADDR_W || DATA_W != `FL_DATA_W || BLOCK_W > 15 || BLOCK_W >= ADDR_W) begin : g_bad_param
    $error("flash_lock_host: unsupported address, data or block width");
  end

  localparam logic [7:0] WE_N  = 8'(`WE_CYC - 1);
  localparam logic [7:0] ACC_N = 8'(`ACC_CYC - 1);
  localparam logic [7:0] REC_N = 8'(`REC_CYC - 1);

  ctl_t                  q;          // registered state
  ctl_t                  next_q;     // next state
  logic                  step_done;  // current bus access fully finished
  logic                  wb_hit;     // new wishbone request this cycle
  logic [7:0]            cmd_byte;   // command byte of the second write step
  logic [ADDR_W-1:0]     id_addr;    // lock config location of target block

  assign step_done = q.acc & q.ph & (q.cnt == 8'h00);
  assign wb_hit    = wb_cyc_i & wb_stb_i & ~q.wb_ack;
  // lock configuration is read inside the addressed block only
  assign id_addr   = {q.addr_reg[ADDR_W-1:BLOCK_W], LOCK_OFS[BLOCK_W-1:0]}; // RL25

  // second write of each two-cycle command except program, which writes its data
  always_comb begin
    unique case (q.op)
      `OP_SET_LOCK:     cmd_byte = CMD_SET_LOCK;  // RL2
      `OP_CLEAR_LOCK:   cmd_byte = CMD_CLR_LOCK;  // RL2
      `OP_SET_LOCKDOWN: cmd_byte = CMD_LOCKDOWN;  // RL2
      `OP_ERASE:        cmd_byte = CMD_CONFIRM;
      default:          cmd_byte = 8'h00;
    endcase
  end

  // whole controller: register file, sequencer and flash bus timing
  always_comb begin
    next_q = q;
    next_q.wb_ack = 1'b0;

    // wishbone slave, one-cycle answer, ack drops the cycle after
    if (wb_hit) begin
      next_q.wb_ack = 1'b1;
      next_q.wb_dat = 32'h0000_0000;
      if (wb_we_i) begin
        unique case (wb_adr_i)
          `REG_CTRL: begin
            // a new order while busy is dropped, never queued
            if (wb_sel_i[1] && wb_dat_i[`CTRL_GO_BIT] && q.st == ST_IDLE && wb_sel_i[0]) begin
              next_q.op = wb_dat_i[`CTRL_OP_LSB +: 4];
              next_q.st = ST_IDLE;
              unique case (wb_dat_i[`CTRL_OP_LSB +: 4])
                `OP_SET_LOCK, `OP_CLEAR_LOCK, `OP_SET_LOCKDOWN,
                `OP_PROGRAM, `OP_ERASE: next_q.st = ST_W1;
                `OP_READ_LOCK:          next_q.st = ST_ID_CMD; // RL20
                `OP_READ_STATUS:        next_q.st = ST_POLL_CMD;
                default:                next_q.st = ST_IDLE;
              endcase
              if (next_q.st != ST_IDLE) begin
                next_q.status_valid = 1'b0;
              end
            end
          end
          `REG_ADDR: begin
            if (q.st == ST_IDLE && wb_sel_i == 4'hf) begin
              next_q.addr_reg = wb_dat_i[ADDR_W-1:0];
            end
          end
          `REG_WDATA: begin
            if (q.st == ST_IDLE && wb_sel_i[1:0] == 2'h3) begin
              next_q.wdata = wb_dat_i[DATA_W-1:0];
            end
          end
          `REG_PINCFG: begin
            if (wb_sel_i[0]) begin
              next_q.pincfg = wb_dat_i[1:0];
            end
          end
          default: begin
            // read-only or unmapped: acknowledged, ignored
          end
        endcase
      end else begin
        unique case (wb_adr_i)
          `REG_CTRL:    next_q.wb_dat = {28'h0, q.op};
          `REG_ADDR:    next_q.wb_dat = 32'(q.addr_reg);
          `REG_WDATA:   next_q.wb_dat = 32'(q.wdata);
          `REG_PINCFG:  next_q.wb_dat = {30'h0, q.pincfg};
          `REG_STATUS:  next_q.wb_dat = {14'h0, q.status_valid, q.st != ST_IDLE, q.engine_status};
          `REG_LOCKCFG: next_q.wb_dat = {30'h0, q.lockdown_bit, q.lock_bit};
          default:      next_q.wb_dat = 32'h0000_0000;
        endcase
      end
    end

    // protect pin follows software; the flash moves its own block states
    next_q.pins.protect_accel_pin = q.pincfg[`PIN_PROTECT_BIT]; // RL3 RL5
    next_q.pins.rst_n             = 1'b1;

    // launch a bus access for the current step
    if (!q.acc && q.st != ST_IDLE && q.st != ST_WAIT_IDLE) begin
      next_q.acc       = 1'b1;
      next_q.ph        = 1'b0;
      next_q.pins.ce_n = 1'b0;
      unique case (q.st)
        ST_POLL_RD, ST_ID_RD: begin
          next_q.pins.oe_n  = 1'b0;
          next_q.pins.dq_oe = 1'b0;
          next_q.cnt        = ACC_N;
          next_q.pins.addr  = (q.st == ST_ID_RD) ? id_addr : q.addr_reg;
        end
        default: begin
          next_q.pins.we_n  = 1'b0;
          next_q.pins.dq_oe = 1'b1;
          next_q.cnt        = WE_N;
          next_q.pins.addr  = q.addr_reg;
          unique case (q.st)
            ST_W1: begin
              if (q.op == `OP_PROGRAM) begin
                next_q.pins.dq = 16'(CMD_PROGRAM);
              end else if (q.op == `OP_ERASE) begin
                next_q.pins.dq = 16'(CMD_ERASE);
              end else begin
                next_q.pins.dq = 16'(CMD_LOCK_SET); // RL2
              end
            end
            ST_W2:       next_q.pins.dq = (q.op == `OP_PROGRAM) ? q.wdata : 16'(cmd_byte);
            ST_POLL_CMD: next_q.pins.dq = 16'(CMD_READ_STAT);
            ST_ID_CMD:   next_q.pins.dq = 16'(CMD_READ_ID); // RL20
            default:     next_q.pins.dq = 16'(CMD_READ_ARR);
          endcase
        end
      endcase
    end else if (q.acc && q.cnt != 8'h00) begin
      // strobe or recovery still running
      next_q.cnt = q.cnt - 8'h01;
    end else if (q.acc && !q.ph) begin
      // strobe ends: catch read data, release strobes, hold data for recovery
      if (!q.pins.oe_n) begin
        next_q.rdata = dq_i;
      end
      next_q.pins.ce_n = 1'b1;
      next_q.pins.oe_n = 1'b1;
      next_q.pins.we_n = 1'b1;
      next_q.ph        = 1'b1;
      next_q.cnt       = REC_N;
    end else if (step_done) begin
      next_q.acc        = 1'b0;
      next_q.ph         = 1'b0;
      next_q.pins.dq_oe = 1'b0;
    end

    // sequencer advance once the access of the step is over
    if (step_done) begin
      unique case (q.st)
        ST_W1: next_q.st = ST_W2;
        // the device checks lock bit and pin level itself; we only poll
        ST_W2: next_q.st = q.pincfg[`PIN_USE_IDLE_BIT] ? ST_WAIT_IDLE : ST_POLL_CMD; // RL17 RL18 RL24
        ST_POLL_CMD: next_q.st = ST_POLL_RD;
        ST_POLL_RD: begin
          // bits 6..1 mean nothing until ready reads 1, so keep re-reading
          if (q.rdata[`SR_READY_BIT]) begin // RL8 RL15 RL19
            next_q.engine_status = q.rdata & `SR_VALID_MASK; // RL7 RL9 RL10 RL11 RL12 RL13 RL14 RL16
            next_q.status_valid  = 1'b1;
            next_q.st            = ST_ARRAY;
          end
        end
        ST_ID_CMD: next_q.st = ST_ID_RD;
        ST_ID_RD: begin
          next_q.lock_bit     = q.rdata[0]; // RL21
          next_q.lockdown_bit = q.rdata[1]; // RL21
          next_q.st           = ST_ARRAY;
        end
        ST_ARRAY: next_q.st = ST_IDLE;
        default:  next_q.st = ST_IDLE;
      endcase
    end

    // idle pin mode: wait for the pin, then confirm through the status word;
    // the pin may still read idle just after the command, so the poll stays
    if (q.st == ST_WAIT_IDLE && engine_idle_pin_i) begin // RL19
      next_q.st = ST_POLL_CMD;
    end
  end

  // single register stage for all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q                          <= '0;
      q.st                       <= ST_IDLE;
      q.op                       <= `OP_RESET;
      q.pincfg                   <= `PINCFG_RESET;
      q.pins.ce_n                <= 1'b1;
      q.pins.oe_n                <= 1'b1;
      q.pins.we_n                <= 1'b1;
      q.pins.rst_n               <= 1'b0; // flash held in reset: all blocks come back locked
      q.pins.protect_accel_pin   <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // outputs come straight from the state flops
  assign flash_o  = q.pins;
  assign wb_ack_o = q.wb_ack;
  assign wb_dat_o = q.wb_dat;

endmodule

// >>> testbench/flash_lock_host_sva.sv
// checker for the flash lock host: wishbone handshake and flash strobes.
// assumes it is bound to flash_lock_host and sees only its ports.
`timescale 1ns/1ps
module flash_lock_host_sva
  import flash_ctl_pkg::*;
(
  // clock, reset and wishbone
  input logic        clk_i,
  input logic        rst_i,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [7:0]  wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o,
  // flash side
  input logic [15:0] dq_i,
  input logic        engine_idle_pin_i,
  input flash_pins_t flash_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // strobe low fourteen cycles, then released
  sequence s_low14(sig);
    !sig[*8] ##1 !sig[*6] ##1 sig;
  endsequence
  // write data stays on the bus through recovery
  sequence s_hold;
    (flash_o.dq_oe && $stable(flash_o.addr))[*6] ##1 !flash_o.dq_oe;
  endsequence
  wire stat_rd = wb_ack_o && !wb_we_i && wb_adr_i == 8'h10; // status answer
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_we_pulse: assert property ($fell(flash_o.we_n) |-> s_low14(flash_o.we_n))
    else $error("write strobe length wrong");
  a_oe_pulse: assert property ($fell(flash_o.oe_n) |-> s_low14(flash_o.oe_n))
    else $error("read strobe length wrong");
  a_write_hold: assert property ($rose(flash_o.we_n) |-> s_hold)
    else $error("write data not held");
  a_no_clash: assert property (!flash_o.oe_n |-> !flash_o.dq_oe && flash_o.we_n)
    else $error("bus driven during read");
  a_strobe_ce: assert property (!flash_o.oe_n || !flash_o.we_n |-> !flash_o.ce_n)
    else $error("strobe without chip enable");
  a_stat_masked: assert property (stat_rd |-> wb_dat_o[15:8] == 8'h00 && !wb_dat_o[0])
    else $error("reserved status bits leak");
  a_valid_ready: assert property (stat_rd && wb_dat_o[17] |-> wb_dat_o[7])
    else $error("status kept while busy");
  a_pin_config: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h0c |->
    ##2 flash_o.protect_accel_pin == $past(wb_dat_i[0], 2)) else $error("protect pin wrong");
endmodule

// >>> testbench/flash_dev_model.sv
// behavioural flash device: per-block lock state, command decoder, status.
// assumes the host pins are registered on the same clock.
`timescale 1ns/1ps
module flash_dev_model
  import flash_ctl_pkg::*;
#(
  parameter int BUSY_CYC = 40 // engine busy time, arbitrary
) (
  // clock and host pins
  input  logic        clk_i,
  input  flash_pins_t pins_i,
  // answer toward the host
  output logic [15:0] dq_o,
  output logic        engine_idle_pin_o
);
  logic       lk [32];   // lock bit per block
  logic       ld [32];   // lock-down bit per block
  logic       hist [32]; // 011 was reached from 110
  logic [7:0] sr;        // engine status
  logic [2:0] mode;      // 0 array 1 status 2 id 3 lock 4 prog 5 erase
  logic       pin_q;     // last protect level
  logic       we_q;      // last write strobe
  int         busy;      // engine cycles left
  logic [4:0] b;         // addressed block
  logic [7:0] c;         // command byte
  // one process: behavioural, so blocking updates are fine here
  always @(posedge clk_i) begin
    b = pins_i.addr[19:15];
    c = pins_i.dq[7:0];
    if (!pins_i.rst_n) begin
      for (int i = 0; i < 32; i++) begin
        lk[i] = 1'b1;
        ld[i] = 1'b0;
        hist[i] = 1'b0;
      end
      sr = 8'h80;
      mode = 3'd0;
      busy = 0;
      dq_o <= 16'h0;
    end else begin
      if (busy > 0) busy--;
      // pin edges move each locked-down block independently
      if (pins_i.protect_accel_pin != pin_q)
        for (int i = 0; i < 32; i++) begin
          if (pins_i.protect_accel_pin && ld[i] && lk[i] && hist[i]) lk[i] = 1'b0;
          if (!pins_i.protect_accel_pin && ld[i]) begin
            hist[i] = !lk[i];
            lk[i] = 1'b1;
          end
        end
      // commands are taken as the write strobe ends
      if (!we_q && pins_i.we_n) begin
        case (mode)
          3'd3: begin
            if (c == 8'h01 || c == 8'hd0 || c == 8'h2f) begin
              if (!ld[b] || pins_i.protect_accel_pin) lk[b] = (c != 8'hd0);
              if (c == 8'h2f && (!ld[b] || pins_i.protect_accel_pin)) ld[b] = 1'b1;
              if (c == 8'h2f) hist[b] = 1'b0;
              busy = 4;
            end else sr[5:4] = 2'b11;
            mode = 3'd1;
          end
          3'd4, 3'd5: begin
            if (mode == 3'd5 && c != 8'hd0) sr[5:4] = 2'b11;
            else begin
              sr[3] = 1'b0;
              if (lk[b]) sr[1] = 1'b1;
              if (mode == 3'd5) sr[5] = 1'b0;
              else sr[4] = 1'b0;
              sr[6] = 1'b0;
              sr[2] = 1'b0;
              busy = BUSY_CYC;
            end
            mode = 3'd1;
          end
          default: mode = (c == 8'h60) ? 3'd3 : (c == 8'h40) ? 3'd4 : (c == 8'h20) ? 3'd5 :
                          (c == 8'h70) ? 3'd1 : (c == 8'h90) ? 3'd2 : 3'd0;
        endcase
      end
      sr[7] = (busy == 0);
      // reserved bits high and busy flags garbled: host must mask
      if (!pins_i.ce_n && !pins_i.oe_n)
        dq_o <= (mode == 3'd1) ? {8'hff, sr[7], busy > 0 ? ~sr[6:1] : sr[6:1], 1'b1} :
                (mode == 3'd2 && pins_i.addr[14:0] == 15'h2) ? {14'h0, ld[b], lk[b]} : 16'h5a3c;
      else
        dq_o <= ~dq_o; // released bus keeps changing
    end
    pin_q = pins_i.protect_accel_pin;
    we_q = pins_i.we_n;
    // registered pin: a blocking view would race the host's own flops
    engine_idle_pin_o <= (busy == 0);
  end
endmodule

// >>> testbench/tb_top.sv
// top testbench: drives the host over wishbone against the flash model.
// assumes the design, its package, the model and the checker compile first.
`timescale 1ns/1ps
module tb_top
  import flash_ctl_pkg::*;
;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, idle;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0, op;
  logic [31:0] wdat = 32'h0, rdat, q, rnd;
  logic [15:0] dq;
  logic [4:0]  blk;
  logic        tlk [32];  // expected lock bits
  flash_pins_t pins;
  int          n_mismatch = 0, cmp_count = 0, seed = 98;
  initial forever #2.5 clk_i = ~clk_i;
  flash_lock_host flash_lock_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .dq_i(dq), .engine_idle_pin_i(idle), .flash_o(pins));
  flash_dev_model flash_dev_model_inst (.clk_i(clk_i), .pins_i(pins), .dq_o(dq), .engine_idle_pin_o(idle));
  function automatic logic [31:0] f_cfg(input logic d, input logic k);
    return {30'h0, d, k};
  endfunction
  // valid, idle, ready plus the locked-block abort flag
  function automatic logic [31:0] f_stat(input logic abort);
    return 32'h20080 | {30'h0, abort, 1'b0};
  endfunction
  task automatic end_of_test();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  // one classic cycle, held until ack under a bound
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    logic got;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    got = (ack === 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (!got) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  // launch an operation and poll until the controller is idle
  task automatic run(input logic [3:0] o, input logic [4:0] k);
    int i;
    wb(1'b1, 8'h04, {12'h0, k, 15'h0});
    wb(1'b1, 8'h00, {23'h0, 1'b1, 4'h0, o});
    i = 0;
    do begin
      wb(1'b0, 8'h10, 32'h0);
      i++;
    end while (q[16] !== 1'b0 && i < 300);
    if (q[16] !== 1'b0) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task automatic lockchk(input logic [4:0] k, input logic [31:0] e);
    run(4'h4, k);
    wb(1'b0, 8'h14, 32'h0);
    check("lockcfg", e, q);
  endtask
  initial begin
    for (int i = 0; i < 32; i++) tlk[i] = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    lockchk(5'd3, f_cfg(1'b0, 1'b1));
    wb(1'b0, 8'h20, 32'h0);
    check("unmapped", 32'h0, q);
    rnd = $random(seed);
    wb(1'b1, 8'h08, rnd);
    wb(1'b0, 8'h08, 32'h0);
    check("wdata", {16'h0, rnd[15:0]}, q);
    wb(1'b1, 8'h00, 32'h109);
    wb(1'b0, 8'h10, 32'h0);
    check("bad op status", 32'h0, q);
    wb(1'b0, 8'h00, 32'h0);
    check("op", 32'h9, q);
    wb(1'b1, 8'h0c, 32'h2); // wait on the idle pin
    run(4'h2, 5'd3);
    run(4'h6, 5'd3);
    check("status", f_stat(1'b0), q);
    run(4'h1, 5'd3);
    run(4'h7, 5'd3);
    check("status", f_stat(1'b1), q);
    run(4'h5, 5'd0);
    check("status", f_stat(1'b1), q);
    run(4'h3, 5'd4);
    run(4'h2, 5'd6);
    run(4'h3, 5'd6);
    lockchk(5'd6, f_cfg(1'b1, 1'b1));
    run(4'h2, 5'd6);
    lockchk(5'd6, f_cfg(1'b1, 1'b1));
    wb(1'b1, 8'h0c, 32'h1);
    lockchk(5'd6, f_cfg(1'b1, 1'b1));
    run(4'h2, 5'd6);
    lockchk(5'd6, f_cfg(1'b1, 1'b0));
    lockchk(5'd3, f_cfg(1'b0, 1'b1));
    wb(1'b1, 8'h0c, 32'h0);
    lockchk(5'd6, f_cfg(1'b1, 1'b1));
    lockchk(5'd3, f_cfg(1'b0, 1'b1));
    wb(1'b1, 8'h0c, 32'h1);
    lockchk(5'd6, f_cfg(1'b1, 1'b0));
    lockchk(5'd4, f_cfg(1'b1, 1'b1));
    wb(1'b1, 8'h0c, 32'h0);
    // mid-run reset: block 6 must come back locked, not locked-down
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    lockchk(5'd6, f_cfg(1'b0, 1'b1));
    repeat (6) begin
      blk = 5'd8 + 5'($random(seed) & 7);
      op = ($random(seed) & 1) ? 4'h1 : 4'h2;
      run(op, blk);
      tlk[blk] = (op == 4'h1);
      lockchk(blk, f_cfg(1'b0, tlk[blk]));
    end
    end_of_test();
  end
endmodule
bind flash_lock_host flash_lock_host_sva flash_lock_host_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dq_i(dq_i),
  .engine_idle_pin_i(engine_idle_pin_i), .flash_o(flash_o));
